// ---- common/strf_map.vh ----
`ifndef STRF_MAP_VH
`define STRF_MAP_VH
// ------------------------------------------------------------------------
// Stream and transparent framing constants
// ------------------------------------------------------------------------
// Sub-carrier mode divider is 64 >> scf, 8..64 carrier cycles.
`define STRF_SC_DIV_BASE    7'h40
// BPSK mode divider is 16 >> scf, 2..16 carrier cycles.
`define STRF_BP_DIV_BASE    7'h10
// Transmit period of code 000b in carrier cycles, doubled per code step.
`define STRF_TX_BASE_CYC    12'h080
// Idle periods beyond which sub-carrier reception ends.
`define STRF_SC_EOR_IDLE    4'h8
// Minimum sub-carrier rising edges in a period counted as detection in sub-carrier mode; BPSK needs one.
`define STRF_DET_MIN_EDGES  7'h02
`define STRF_FIFO_WIDTH     8
`define STRF_FIFO_DEPTH     16
`define STRF_FIFO_AW        4
`define STRF_CNT_W          12
// Protocol mode codes.
`define STRF_MODE_FRAMED    2'h0
`define STRF_MODE_SUBC      2'h1
`define STRF_MODE_BPSK      2'h2
`endif

// ---- hdl/strf_fifo.v ----
`timescale 1ns/10ps
module strf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire             flush_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg  [AW:0]      wr_reg;
    reg  [AW:0]      rd_reg;
    wire             full;
    wire             empty;
    wire             push;
    wire             pop;
    genvar           g;

    assign full        = (wr_reg[AW] != rd_reg[AW]) &&
                         (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty       = (wr_reg == rd_reg);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign push        = in_valid_i & ~full;
    assign pop         = out_ready_i & ~empty;
    assign out_data_o  = mem_reg[rd_reg[AW-1:0]];

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= wr_reg + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_reg <= rd_reg + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            always @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem_reg[g] <= {WIDTH{1'b0}};
                end else if (push && (wr_reg[AW-1:0] == g)) begin
                    mem_reg[g] <= in_data_i;
                end
            end
        end
    endgenerate
endmodule // strf_fifo

// ---- hdl/strf_core.v ----
// Functional notes
// - Transparent starts at select rise after entry command; held while high.
// - In transparent mode serial data input high turns the modulator on.
// - In transparent mode serial clock high enables RSSI and AGC.
// - AM channel goes to serial output, PM channel to interrupt pin.
// - Single selected channel goes to serial output; interrupt pin held low.
// - Transparent mode ignores protocol, framing and FIFO settings only.
// - Any later serial command ends transparent mode; host must re-enter.
// - Field detect on in transparent mode puts detector on interrupt pin.
// - Field detect on, operation bits all zero: low-power target state.
// - First stream bit sits at the FIFO byte least significant bit.
// - Sub-carrier reception supports fc/64 to fc/8.
// - Sub-carrier reporting period is two to eight sub-carrier cycles.
// - First sub-carrier period raises start-of-receive, stores first bit.
// - Sub-carrier bit is one when sub-carrier seen during the period.
// - Sub-carrier reception ends after more than eight idle periods.
// - Sub-carrier scf 01b gives fc/32, scp 10b gives four cycles.
// - BPSK supports fc/16 to fc/2 and one to eight cycles.
// - BPSK bit is zero for initial phase, one for inverted phase.
// - BPSK reception ends at first period without sub-carrier.
// - BPSK scf 01b gives fc/8, scp 01b gives two cycles.
// - Each transmit FIFO bit holds modulation for one period; 000b is 128.
`timescale 1ns/10ps
`include "strf_map.vh"
module strf_core (
    input  wire       clock_i,
    input  wire       resetn_i,
    input  wire       fc_i,
    input  wire       ss_n_i,
    input  wire       sclk_i,
    input  wire       mosi_i,
    input  wire       cmd_transparent_i,
    input  wire       cmd_other_i,
    input  wire       cmd_transmit_i,
    input  wire [1:0] proto_mode_i,
    input  wire [1:0] scf_i,
    input  wire [1:0] scp_i,
    input  wire [2:0] stx_i,
    input  wire       am_chan_en_i,
    input  wire       pm_chan_en_i,
    input  wire       ext_field_detect_enable_i,
    input  wire [7:0] op_control_i,
    input  wire       am_subc_i,
    input  wire       pm_subc_i,
    input  wire       ext_field_i,
    input  wire [7:0] tx_data_i,
    input  wire       tx_valid_i,
    output reg        tx_ready_o,
    output reg  [7:0] rx_data_o,
    output reg        rx_valid_o,
    input  wire       rx_ready_i,
    output reg        transparent_o,
    output reg        modulate_o,
    output reg        rx_on_o,
    output reg        miso_o,
    output reg        miso_oe_n_o,
    output reg        irq_o,
    output reg        sor_o,
    output reg        eor_o,
    output reg        low_power_target_o,
    output reg        rx_overflow_o
);
    // --------------------------------------------------------------------
    // Reset release and pin synchronisers
    // --------------------------------------------------------------------
    reg        rst_a_reg;
    reg        rst_n;
    reg  [5:0] s1_reg;
    reg  [5:0] s2_reg;
    reg        ss_d_reg;
    wire       fc_rise;
    wire       ss_rise;

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_a_reg <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_n     <= rst_a_reg;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= 6'h01;
            s2_reg   <= 6'h01;
            ss_d_reg <= 1'b1;
        end else begin
            s1_reg   <= {ext_field_i, pm_subc_i, am_subc_i,
                         mosi_i, sclk_i, ss_n_i};
            s2_reg   <= s1_reg;
            ss_d_reg <= s2_reg[0];
        end
    end

    reg fc1_reg;
    reg fc2_reg;
    reg fc3_reg;
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            fc1_reg <= 1'b0;
            fc2_reg <= 1'b0;
            fc3_reg <= 1'b0;
        end else begin
            fc1_reg <= fc_i;
            fc2_reg <= fc1_reg;
            fc3_reg <= fc2_reg;
        end
    end
    assign fc_rise = fc2_reg & ~fc3_reg;
    assign ss_rise = s2_reg[0] & ~ss_d_reg;

    // --------------------------------------------------------------------
    // Transparent mode control
    // --------------------------------------------------------------------
    reg armed_reg;
    reg trans_reg;
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
            trans_reg <= 1'b0;
        end else begin
            if (cmd_other_i || cmd_transmit_i) begin
                armed_reg <= 1'b0;
                trans_reg <= 1'b0;
            end else if (cmd_transparent_i) begin
                armed_reg <= 1'b1;
                trans_reg <= 1'b0;
            end else if (armed_reg && ss_rise) begin
                armed_reg <= 1'b0;
                trans_reg <= 1'b1;
            end else if (trans_reg && !s2_reg[0]) begin
                trans_reg <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // Stream timing: carrier-cycle counters
    // --------------------------------------------------------------------
    reg  [6:0]  sc_div;
    reg  [3:0]  sc_cyc;
    reg  [11:0] rp_len;
    reg  [15:0] tx_len;
    wire        sc_mode;
    wire        bp_mode;

    assign sc_mode = (proto_mode_i == `STRF_MODE_SUBC) & ~trans_reg;
    assign bp_mode = (proto_mode_i == `STRF_MODE_BPSK) & ~trans_reg;

    always @* begin
        if (bp_mode) begin
            sc_div = `STRF_BP_DIV_BASE >> scf_i;
            sc_cyc = 4'h1 << scp_i;
        end else begin
            sc_div = `STRF_SC_DIV_BASE >> scf_i;
            // Cycles double per code step; code 00b is held at two cycles.
            sc_cyc = (scp_i == 2'h0) ? 4'h2 : (4'h1 << scp_i);
        end
        rp_len = {5'h00, sc_div} * {8'h00, sc_cyc};
        tx_len = {4'h0, `STRF_TX_BASE_CYC} << stx_i;
    end

    // --------------------------------------------------------------------
    // Receive: sub-carrier detection per reporting period
    // --------------------------------------------------------------------
    reg  [11:0] rp_cnt_reg;
    reg  [6:0]  edges_reg;
    reg  [11:0] ph_cnt_reg;
    reg         sub_d_reg;
    reg         ref_ph_reg;
    reg         rx_act_reg;
    reg  [3:0]  idle_reg;
    reg  [7:0]  sh_reg;
    reg  [3:0]  nb_reg;
    reg         push_reg;
    reg  [7:0]  push_data_reg;
    wire        sub_in;
    wire        sub_edge;
    wire        rp_end;
    wire        det;
    wire        bit_ph;
    wire        f_ready;
    wire [7:0]  f_data;
    wire        f_valid;
    wire        f_pop;

    assign sub_in   = am_chan_en_i ? s2_reg[3] : s2_reg[4];
    assign sub_edge = sub_in & ~sub_d_reg;
    assign rp_end   = fc_rise && (rp_cnt_reg >= rp_len - 12'h001);
    assign det      = (edges_reg >= `STRF_DET_MIN_EDGES) ||
                      (bp_mode && edges_reg != 7'h00);
    // Phase of the period is the carrier count at its last rising edge.
    assign bit_ph   = ph_cnt_reg >= {5'h00, sc_div >> 1};

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rp_cnt_reg    <= 12'h000;
            edges_reg     <= 7'h00;
            ph_cnt_reg    <= 12'h000;
            sub_d_reg     <= 1'b0;
            ref_ph_reg    <= 1'b0;
            rx_act_reg    <= 1'b0;
            idle_reg      <= 4'h0;
            sh_reg        <= 8'h00;
            nb_reg        <= 4'h0;
            push_reg      <= 1'b0;
            push_data_reg <= 8'h00;
            sor_o         <= 1'b0;
            eor_o         <= 1'b0;
        end else begin
            sub_d_reg <= sub_in;
            push_reg  <= 1'b0;
            sor_o     <= 1'b0;
            eor_o     <= 1'b0;
            if (!(sc_mode || bp_mode)) begin
                rp_cnt_reg <= 12'h000;
                edges_reg  <= 7'h00;
                rx_act_reg <= 1'b0;
            end else begin
                if (sub_edge) begin
                    edges_reg  <= edges_reg + 7'h01;
                    ph_cnt_reg <= rp_cnt_reg % {5'h00, sc_div};
                end
                if (fc_rise) begin
                    rp_cnt_reg <= rp_end ? 12'h000 : rp_cnt_reg + 12'h001;
                end
                if (rp_end) begin
                    edges_reg <= 7'h00;
                    if (!rx_act_reg) begin
                        if (det) begin
                            rx_act_reg <= 1'b1;
                            sor_o      <= 1'b1;
                            ref_ph_reg <= bit_ph;
                            idle_reg   <= 4'h0;
                            sh_reg     <= {7'h00, ~bp_mode};
                            nb_reg     <= 4'h1;
                        end
                    end else if (bp_mode && !det) begin
                        rx_act_reg <= 1'b0;
                        eor_o      <= 1'b1;
                        if (nb_reg != 4'h0) begin
                            push_reg      <= 1'b1;
                            push_data_reg <= sh_reg;
                        end
                    end else if (sc_mode && !det &&
                                 idle_reg == `STRF_SC_EOR_IDLE) begin
                        rx_act_reg <= 1'b0;
                        eor_o      <= 1'b1;
                        if (nb_reg != 4'h0) begin
                            push_reg      <= 1'b1;
                            push_data_reg <= sh_reg;
                        end
                    end else begin
                        idle_reg <= det ? 4'h0 : idle_reg + 4'h1;
                        if (nb_reg == 4'h7) begin
                            push_reg      <= 1'b1;
                            push_data_reg <= sh_reg |
                                (bp_mode ? {bit_ph ^ ref_ph_reg, 7'h00}
                                         : {det, 7'h00});
                            sh_reg        <= 8'h00;
                            nb_reg        <= 4'h0;
                        end else begin
                            // Later bits fill higher positions.
                            sh_reg <= sh_reg | ((bp_mode ?
                                {7'h00, bit_ph ^ ref_ph_reg} :
                                {7'h00, det}) << nb_reg[2:0]);
                            nb_reg <= nb_reg + 4'h1;
                        end
                    end
                end
            end
        end
    end

    strf_fifo #(
        .WIDTH (`STRF_FIFO_WIDTH),
        .DEPTH (`STRF_FIFO_DEPTH),
        .AW    (`STRF_FIFO_AW)
    ) u_rx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n),
        .flush_i     (trans_reg),
        .in_data_i   (push_data_reg),
        .in_valid_i  (push_reg),
        .in_ready_o  (f_ready),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop)
    );

    // Output skid: load the register stage whenever it is empty or taken.
    assign f_pop = f_valid & (~rx_valid_o | rx_ready_i);

    // --------------------------------------------------------------------
    // Transmit stream and pin outputs
    // --------------------------------------------------------------------
    reg  [15:0] tx_cnt_reg;
    reg  [7:0]  tx_sh_reg;
    reg  [3:0]  tx_nb_reg;
    reg         tx_run_reg;

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_reg         <= 16'h0000;
            tx_sh_reg          <= 8'h00;
            tx_nb_reg          <= 4'h0;
            tx_run_reg         <= 1'b0;
            tx_ready_o         <= 1'b0;
            rx_data_o          <= 8'h00;
            rx_valid_o         <= 1'b0;
            transparent_o      <= 1'b0;
            modulate_o         <= 1'b0;
            rx_on_o            <= 1'b0;
            miso_o             <= 1'b0;
            miso_oe_n_o        <= 1'b1;
            irq_o              <= 1'b0;
            low_power_target_o <= 1'b0;
            rx_overflow_o      <= 1'b0;
        end else begin
            tx_ready_o <= 1'b0;
            if (cmd_transmit_i && (sc_mode || bp_mode)) begin
                tx_run_reg <= 1'b1;
                tx_nb_reg  <= 4'h0;
                tx_cnt_reg <= 16'h0000;
            end else if (tx_run_reg && tx_nb_reg == 4'h0) begin
                if (tx_valid_i) begin
                    tx_ready_o <= 1'b1;
                    tx_sh_reg  <= tx_data_i;
                    tx_nb_reg  <= 4'h8;
                    tx_cnt_reg <= 16'h0000;
                end else begin
                    tx_run_reg <= 1'b0;
                end
            end else if (tx_run_reg && fc_rise) begin
                if (tx_cnt_reg >= tx_len - 16'h0001) begin
                    tx_cnt_reg <= 16'h0000;
                    tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                    tx_nb_reg  <= tx_nb_reg - 4'h1;
                end else begin
                    tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                end
            end
            if (f_pop) begin
                rx_data_o  <= f_data;
                rx_valid_o <= 1'b1;
            end else if (rx_ready_i) begin
                rx_valid_o <= 1'b0;
            end
            rx_overflow_o <= push_reg & ~f_ready;
            transparent_o <= trans_reg;
            low_power_target_o <= ext_field_detect_enable_i &&
                                  op_control_i == 8'h00;
            if (trans_reg) begin
                modulate_o  <= s2_reg[2];
                rx_on_o     <= s2_reg[1];
                miso_oe_n_o <= 1'b0;
                if (am_chan_en_i && pm_chan_en_i) begin
                    miso_o <= s2_reg[3];
                    irq_o  <= ext_field_detect_enable_i ?
                              s2_reg[5] : s2_reg[4];
                end else begin
                    miso_o <= am_chan_en_i ? s2_reg[3] : s2_reg[4];
                    irq_o  <= ext_field_detect_enable_i ?
                              s2_reg[5] : 1'b0;
                end
            end else begin
                // Stream bits modulate LSB first while the transmitter runs.
                modulate_o  <= tx_run_reg && tx_nb_reg != 4'h0 &&
                               tx_sh_reg[0];
                rx_on_o     <= 1'b0;
                miso_oe_n_o <= 1'b1;
                miso_o      <= 1'b0;
                irq_o       <= 1'b0;
            end
        end
    end
endmodule // strf_core

// ---- hdl/strf_core_note.v ----
`timescale 1ns/10ps

// ---- dv/strf_core_sva.sv ----
`timescale 1ns/10ps
// ---------------------------------------------
// Port checker for the framing core.
// ---------------------------------------------
module strf_core_sva (
    input wire       clock_i,
    input wire       resetn_i,
    input wire       ss_n_i,
    input wire       sclk_i,
    input wire       mosi_i,
    input wire       cmd_other_i,
    input wire       am_chan_en_i,
    input wire       pm_chan_en_i,
    input wire       ext_field_detect_enable_i,
    input wire [7:0] op_control_i,
    input wire       am_subc_i,
    input wire       transparent_o,
    input wire       modulate_o,
    input wire       rx_on_o,
    input wire       miso_o,
    input wire       miso_oe_n_o,
    input wire       irq_o,
    input wire       sor_o,
    input wire       eor_o,
    input wire       low_power_target_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    property p_enter;
        $rose(transparent_o) |-> ss_n_i;
    endproperty
    a_enter: assert property (p_enter)
        else $error("transparent entered while select low");
    property p_mod;
        (transparent_o && $stable(mosi_i))[*5] |-> modulate_o == mosi_i;
    endproperty
    a_mod: assert property (p_mod)
        else $error("modulator does not follow data input");
    property p_rxon;
        (transparent_o && $stable(sclk_i))[*5] |-> rx_on_o == sclk_i;
    endproperty
    a_rxon: assert property (p_rxon)
        else $error("receiver enable does not follow serial clock");
    property p_miso;
        (transparent_o && am_chan_en_i && $stable(am_subc_i))[*5]
            |-> miso_o == am_subc_i && !miso_oe_n_o;
    endproperty
    a_miso: assert property (p_miso)
        else $error("serial output does not carry amplitude channel");
    property p_irq_single;
        (transparent_o && (am_chan_en_i != pm_chan_en_i)
            && !ext_field_detect_enable_i ##1 transparent_o) |-> !irq_o;
    endproperty
    a_irq_single: assert property (p_irq_single)
        else $error("interrupt pin not low with one channel");
    property p_quiet;
        transparent_o |-> !sor_o && !eor_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("stream event during transparent operation");
    property p_exit;
        cmd_other_i |-> ##[1:3] !transparent_o;
    endproperty
    a_exit: assert property (p_exit)
        else $error("transparent operation survives a command");
    property p_lpt;
        $stable({ext_field_detect_enable_i, op_control_i})[*3] |->
            low_power_target_o ==
            (ext_field_detect_enable_i && op_control_i == 8'h00);
    endproperty
    a_lpt: assert property (p_lpt)
        else $error("low-power target state wrong");
    property p_events;
        (sor_o || eor_o) |=> !(sor_o || eor_o);
    endproperty
    a_events: assert property (p_events)
        else $error("receive event longer than one cycle");
endmodule // strf_core_sva

// ---- dv/strf_host_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------
// Host side of the serial pins.
// ---------------------------------------------
module strf_host_model (
    input  wire      clock_i,
    input  wire      enter_i,
    input  wire      leave_i,
    input  wire      mosi_want_i,
    input  wire      sclk_want_i,
    output reg       cmd_transparent_o = 1'b0,
    output reg       cmd_other_o = 1'b0,
    output reg       ss_n_o = 1'b1,
    output reg       sclk_o = 1'b0,
    output reg       mosi_o = 1'b0
);
    reg [2:0] wait_reg = 3'h0;
    reg       session  = 1'b0;
    // A command frame holds select low; select rises when it ends.
    always @(posedge clock_i) begin
        cmd_transparent_o <= 1'b0;
        cmd_other_o <= 1'b0;
        if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
            ss_n_o <= (wait_reg == 3'h1);
        end else if (enter_i || leave_i) begin
            cmd_transparent_o <= enter_i;
            cmd_other_o <= leave_i;
            ss_n_o <= 1'b0;
            wait_reg <= 3'h4;
            session <= enter_i;
        end
        // Outside a session the data line is not driven and wanders.
        if (session && ss_n_o) begin
            mosi_o <= mosi_want_i;
            sclk_o <= sclk_want_i;
        end else begin
            mosi_o <= ~mosi_o;
            sclk_o <= 1'b0;
        end
    end
endmodule // strf_host_model

// ---- dv/strf_core_tb.sv ----
`timescale 1ns/10ps
module strf_core_tb;
    reg        clock_i = 1'b0, resetn_i = 1'b0, fc_i = 1'b0;
    reg        cmd_transmit_i = 1'b0, am_chan_en_i = 1'b1;
    reg        pm_chan_en_i = 1'b1, efd = 1'b0;
    reg  [1:0] proto_mode_i = 2'h0, scf_i = 2'h1, scp_i = 2'h2;
    reg  [7:0] op_control_i = 8'hFF, tx_data_i = 8'h00;
    reg        am_subc_i = 1'b0, pm_subc_i = 1'b0, ext_field_i = 1'b0;
    reg        tx_valid_i = 1'b0, rx_ready_i = 1'b0, enter = 1'b0;
    reg        leave = 1'b0, w_mosi = 1'b0, w_sclk = 1'b0;
    reg        sub_on = 1'b0, got = 1'b0, sor_seen = 1'b0, w_am = 1'b0;
    reg [31:0] seed = 32'h8EE3, fcnt = 32'h0, fbase = 32'h0, t_eor = 32'h0;
    reg  [7:0] rx_pat, got_byte, txb;
    integer    errors = 0, comparisons = 0, cycles = 0, i, k;
    wire       ss_n, sclk, mosi, c_tr, c_ot, tx_ready_o, rx_valid_o;
    wire       transparent_o, modulate_o, rx_on_o, miso_o, irq_o, sor_o;
    wire       eor_o, lpt;
    wire [7:0] rx_data_o;
    wire [31:0] rel = fcnt - fbase;
    strf_host_model u_host (.clock_i(clock_i), .enter_i(enter),
        .leave_i(leave), .mosi_want_i(w_mosi), .sclk_want_i(w_sclk),
        .cmd_transparent_o(c_tr), .cmd_other_o(c_ot), .ss_n_o(ss_n),
        .sclk_o(sclk), .mosi_o(mosi));
    strf_core u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .fc_i(fc_i),
        .ss_n_i(ss_n), .sclk_i(sclk), .mosi_i(mosi),
        .cmd_transparent_i(c_tr), .cmd_other_i(c_ot),
        .cmd_transmit_i(cmd_transmit_i), .proto_mode_i(proto_mode_i),
        .scf_i(scf_i), .scp_i(scp_i), .stx_i(3'h0),
        .am_chan_en_i(am_chan_en_i), .pm_chan_en_i(pm_chan_en_i),
        .ext_field_detect_enable_i(efd), .op_control_i(op_control_i),
        .am_subc_i(am_subc_i), .pm_subc_i(pm_subc_i),
        .ext_field_i(ext_field_i), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .transparent_o(transparent_o),
        .modulate_o(modulate_o), .rx_on_o(rx_on_o), .miso_o(miso_o),
        .miso_oe_n_o(), .irq_o(irq_o), .sor_o(sor_o), .eor_o(eor_o),
        .low_power_target_o(lpt), .rx_overflow_o());
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input [7:0] got_v, input [7:0] exp_v);
        begin
            comparisons = comparisons + 1;
            if (got_v !== exp_v) begin
                errors = errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got_v,
                         exp_v);
            end
        end
    endtask
    task wrap_up;
        begin
            if (errors == 0 && comparisons > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial forever #2.5 clock_i = ~clock_i;
    initial begin
        #3;
        forever #32 fc_i = ~fc_i;
    end
    always @(posedge fc_i) fcnt <= fcnt + 32'h1;
    // -----------------------------------------
    // Tag model: sub-carrier at fc/32, four cycles per reporting period.
    // -----------------------------------------
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors = errors + 1;
            wrap_up;
        end
        am_subc_i <= sub_on ? rel < 1024 && rx_pat[rel[9:7]] && rel[4] : w_am;
        sor_seen <= sor_seen | (sor_o === 1'b1);
        if (eor_o === 1'b1) t_eor <= rel;
        if (rx_valid_o === 1'b1 && rx_ready_i && !got) begin
            got <= 1'b1;
            got_byte <= rx_data_o;
        end
    end
    initial begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        efd <= 1'b1;
        op_control_i <= 8'h00;
        repeat (6) @(posedge clock_i);
        check(lpt, 8'h01);
        seed = lfsr(seed);
        op_control_i <= seed[7:0] | 8'h01;
        repeat (6) @(posedge clock_i);
        check(lpt, 8'h00);
        for (k = 0; k < 3; k = k + 1) begin
            pm_chan_en_i <= (k != 1);
            efd <= (k == 2);
            enter <= 1'b1;
            @(posedge clock_i);
            enter <= 1'b0;
            for (i = 0; i < 30 && transparent_o !== 1'b1; i = i + 1)
                @(negedge clock_i);
            check(transparent_o, 8'h01);
            for (i = 0; i < 4; i = i + 1) begin
                seed = lfsr(seed);
                @(posedge clock_i);
                {w_mosi, w_sclk, w_am, pm_subc_i} <= seed[3:0];
                {ext_field_i, proto_mode_i, rx_ready_i} <= seed[7:4];
                repeat (8) @(posedge clock_i);
                check(modulate_o, seed[3]);
                check(rx_on_o, seed[2]);
                check(miso_o, seed[1]);
                check(irq_o, k[1] ? seed[7] : !k && seed[0]);
            end
            leave <= 1'b1;
            @(posedge clock_i);
            leave <= 1'b0;
            repeat (12) @(posedge clock_i);
            check(transparent_o, 8'h00);
        end
        efd <= 1'b0;
        op_control_i <= 8'hFF;
        proto_mode_i <= 2'h1;
        rx_ready_i <= 1'b0;
        pm_subc_i <= 1'b0;
        seed = lfsr(seed);
        rx_pat = seed[7:0] | 8'h81;
        @(negedge fc_i);
        fbase = fcnt;
        sub_on = 1'b1;
        for (i = 0; i < 40000 && t_eor == 0; i = i + 1) @(negedge clock_i);
        check(t_eor >= 2048 && t_eor <= 2304, 8'h01);
        @(posedge clock_i);
        rx_ready_i <= 1'b1;
        for (i = 0; i < 40 && !got; i = i + 1) @(negedge clock_i);
        check(sor_seen, 8'h01);
        check(got_byte, rx_pat);
        sub_on = 1'b0;
        txb = seed[15:8];
        @(posedge clock_i);
        tx_data_i <= txb;
        tx_valid_i <= 1'b1;
        cmd_transmit_i <= 1'b1;
        @(posedge clock_i);
        cmd_transmit_i <= 1'b0;
        for (i = 0; i < 20 && tx_ready_o !== 1'b1; i = i + 1)
            @(negedge clock_i);
        fbase = fcnt;
        @(posedge clock_i);
        tx_valid_i <= 1'b0;
        for (k = 0; k < 8; k = k + 1) begin
            wait (rel >= 64 + 128 * k);
            check(modulate_o, txb[k]);
        end
        wrap_up;
    end
endmodule // strf_core_tb
bind strf_core strf_core_sva u_sva (.clock_i(clock_i), .resetn_i(resetn_i),
    .ss_n_i(ss_n_i), .sclk_i(sclk_i), .mosi_i(mosi_i),
    .cmd_other_i(cmd_other_i), .am_chan_en_i(am_chan_en_i),
    .pm_chan_en_i(pm_chan_en_i),
    .ext_field_detect_enable_i(ext_field_detect_enable_i),
    .op_control_i(op_control_i), .am_subc_i(am_subc_i),
    .transparent_o(transparent_o), .modulate_o(modulate_o),
    .rx_on_o(rx_on_o), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
    .irq_o(irq_o), .sor_o(sor_o), .eor_o(eor_o),
    .low_power_target_o(low_power_target_o));
